/* inc/sdac_regs.svh */
// constants for the stereo dac serial input: timing counts, field positions, ratio figures
// assumes the core clock runs at 200 MHz and every link pin is sampled by that clock
`ifndef SDAC_REGS_SVH
`define SDAC_REGS_SVH

`define SDAC_WORD_BITS     24
`define SDAC_CLK_MHZ       200
`define SDAC_CLK_HZ        200000000
// activity windows and the ramp tick, in ns, turned into core cycles below
`define SDAC_MCLK_IDLE_NS  1000
`define SDAC_BCLK_IDLE_NS  20000
`define SDAC_RAMP_TICK_NS  20000
`define SDAC_MCLK_IDLE_CYC ((`SDAC_MCLK_IDLE_NS * `SDAC_CLK_MHZ) / 1000)
`define SDAC_BCLK_IDLE_CYC ((`SDAC_BCLK_IDLE_NS * `SDAC_CLK_MHZ) / 1000)
`define SDAC_RAMP_TICK_CYC ((`SDAC_RAMP_TICK_NS * `SDAC_CLK_MHZ) / 1000)
`define SDAC_IDLE_BITS     12
`define SDAC_RAMP_LEN      800
`define SDAC_GAIN_BITS     10
`define SDAC_RATIO_TOL     32
// nominal master clocks per frame for each supported ratio
`define SDAC_NOM_R128      128
`define SDAC_NOM_R192      192
`define SDAC_NOM_R256      256
`define SDAC_NOM_R384      384
`define SDAC_NOM_R512      512
`define SDAC_NOM_R768      768
`define SDAC_NOM_R1152     1152
`define SDAC_MCNT_BITS     11
`define SDAC_FCNT_BITS     16
`define SDAC_FS_SLACK      16
`define SDAC_FS_88K2_HZ    88200
`define SDAC_FS_96K_HZ     96000
`define SDAC_FS_48K_HZ     48000
`define SDAC_FS_32K_HZ     32000
// sync vector positions
`define SDAC_SY_MCLK       0
`define SDAC_SY_BCLK       1
`define SDAC_SY_LR         2
`define SDAC_SY_SD         3
`define SDAC_SY_MUTE       4
`define SDAC_SY_FMT        5
`define SDAC_SY_FLOAT      6
`define SDAC_SY_POR        7
`define SDAC_SY_BITS       8
// source end divider: mclk 128fs, bclk 64fs
`define SDAC_MCLK_HALF     8
`define SDAC_BCLK_PER      32
`define SDAC_BCLK_HALF     16
`define SDAC_SLOTS         64
`define SDAC_SLOT_LSB_RTJ  8

`endif

/* inc/sdac_pkg.sv */
// types shared by both ends of the stereo serial audio link
// assumes sdac_regs.svh supplies the numeric constants
package sdac_pkg;

  typedef enum logic [1:0] {
    SDAC_PWR_OFF     = 2'b00,
    SDAC_PWR_STANDBY = 2'b01,
    SDAC_PWR_ENABLED = 2'b10
  } sdac_pwr_t;

  typedef enum logic [1:0] {
    SDAC_FMT_LEFT_JUSTIFIED  = 2'b00,
    SDAC_FMT_I2S             = 2'b01,
    SDAC_FMT_RIGHT_JUSTIFIED = 2'b10
  } sdac_fmt_t;

  typedef enum logic [2:0] {
    SDAC_R128  = 3'b000,
    SDAC_R192  = 3'b001,
    SDAC_R256  = 3'b010,
    SDAC_R384  = 3'b011,
    SDAC_R512  = 3'b100,
    SDAC_R768  = 3'b101,
    SDAC_R1152 = 3'b110,
    SDAC_RNONE = 3'b111
  } sdac_ratio_t;

endpackage : sdac_pkg

/* inc/sdac_link_if.sv */
// four-wire serial audio link (master clock, bit clock, frame sync, data) plus mute and three-state format pin
// assumes the source end drives every wire; the device only listens
`timescale 1ns/1ps
`default_nettype none
interface sdac_link_if;
  logic master_clock;
  logic bit_clock;
  logic frame_sync;
  logic serial_audio_in;
  logic mute_n;
  logic format_select_out;
  logic format_select_oe_n;

  modport dev (
    input master_clock,
    input bit_clock,
    input frame_sync,
    input serial_audio_in,
    input mute_n,
    input format_select_out,
    input format_select_oe_n
  );

  modport src (
    output master_clock,
    output bit_clock,
    output frame_sync,
    output serial_audio_in,
    output mute_n,
    output format_select_out,
    output format_select_oe_n
  );
endinterface : sdac_link_if
`default_nettype wire

/* hdl/sdac_src_end.sv */
// audio source end: makes master clock, bit clock, frame sync and data
// assumes i_clk at 200 MHz; the link clocks come from dividers on it
`include "sdac_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sdac_src_end (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  sdac_link_if.src                        lnk,
  input  wire logic [`SDAC_WORD_BITS-1:0] i_left,
  input  wire logic [`SDAC_WORD_BITS-1:0] i_right,
  input  wire logic                       i_mute_n,
  input  wire sdac_pkg::sdac_fmt_t        i_fmt,
  input  wire logic                       i_mclk_run,
  input  wire logic                       i_bclk_run,
  output logic                            o_take
);
  logic [2:0]                 mdiv_q;
  logic [4:0]                 bph_q;
  logic [5:0]                 slot_q;
  logic                       mclk_q, bclk_q, lr_q, sd_q, mute_q, fmt_q, fmt_oe_n_q;
  logic [`SDAC_WORD_BITS-1:0] cur_l_q, cur_r_q;

  // ****************************************************************
  // slot decode
  // ****************************************************************
  wire                       half_w   = slot_q[5];
  wire [4:0]                 s_w      = slot_q[4:0];
  wire                       fall_w   = i_bclk_run && (bph_q == 5'h00);
  wire                       rise_w   = i_bclk_run && (bph_q == 5'(`SDAC_BCLK_HALF));
  wire [`SDAC_WORD_BITS-1:0] word_w   = half_w ? cur_r_q : cur_l_q;
  wire                       is_i2s_w = (i_fmt == sdac_pkg::SDAC_FMT_I2S);
  // justified formats put left on high frame sync, i2s on low
  wire                       lr_w     = is_i2s_w ? half_w : ~half_w;
  wire [5:0]                 s6_w     = {1'b0, s_w};
  wire                       lfj_in_w = (s6_w < 6'(`SDAC_WORD_BITS));
  wire                       i2s_in_w = (s_w != 5'h00) && (s6_w <= 6'(`SDAC_WORD_BITS));
  wire                       rtj_in_w = (s_w >= 5'(`SDAC_SLOT_LSB_RTJ));
  wire [4:0]                 lfj_ix_w = 5'(`SDAC_WORD_BITS - 1) - s_w;
  wire [4:0]                 i2s_ix_w = 5'(`SDAC_WORD_BITS) - s_w;
  wire [4:0]                 rtj_ix_w = 5'h1f - s_w;
  wire                       bit_w    =
      (i_fmt == sdac_pkg::SDAC_FMT_LEFT_JUSTIFIED) ? (lfj_in_w && word_w[lfj_ix_w]) :
      is_i2s_w ? (i2s_in_w && word_w[i2s_ix_w]) :
      (rtj_in_w && word_w[rtj_ix_w]);

  // ****************************************************************
  // dividers
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_mclk_run) begin
      mdiv_q <= 3'h0;
      mclk_q <= 1'b0;
    end else begin
      mdiv_q <= mdiv_q + 3'h1;
      if (mdiv_q == 3'(`SDAC_MCLK_HALF - 1)) begin
        mclk_q <= ~mclk_q;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bph_q  <= 5'h00;
      slot_q <= 6'h00;
      bclk_q <= 1'b0;
    end else if (i_bclk_run) begin
      bph_q <= bph_q + 5'h01;
      if (bph_q == 5'(`SDAC_BCLK_PER - 1)) begin
        slot_q <= slot_q + 6'h01;
      end
      if (fall_w) begin
        bclk_q <= 1'b0;
      end else if (rise_w) begin
        bclk_q <= 1'b1;
      end
    end
  end

  // data and frame sync change while the bit clock is low
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lr_q    <= 1'b0;
      sd_q    <= 1'b0;
      cur_l_q <= '0;
      cur_r_q <= '0;
      o_take  <= 1'b0;
    end else begin
      o_take <= fall_w && (slot_q == 6'h00);
      if (fall_w && (slot_q == 6'h00)) begin
        cur_l_q <= i_left;
        cur_r_q <= i_right;
      end
      if (fall_w) begin
        lr_q <= lr_w;
        sd_q <= bit_w;
      end
    end
  end

  // right-justified leaves the format pin floating
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mute_q     <= 1'b0;
      fmt_q      <= 1'b0;
      fmt_oe_n_q <= 1'b1;
    end else begin
      mute_q     <= i_mute_n;
      fmt_q      <= is_i2s_w;
      fmt_oe_n_q <= (i_fmt == sdac_pkg::SDAC_FMT_RIGHT_JUSTIFIED);
    end
  end

  assign lnk.master_clock       = mclk_q;
  assign lnk.bit_clock          = bclk_q;
  assign lnk.frame_sync         = lr_q;
  assign lnk.serial_audio_in    = sd_q;
  assign lnk.mute_n             = mute_q;
  assign lnk.format_select_out  = fmt_q;
  assign lnk.format_select_oe_n = fmt_oe_n_q;
endmodule : sdac_src_end
`default_nettype wire

/* hdl/sdac_dev_end.sv */
// dac end: receives the serial link, measures clock ratio, soft mute, power states
// assumes every link pin is asynchronous to i_clk and sampled at 200 MHz;
// i_power_on_reset_n comes from the analogue supply comparators
`include "sdac_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sdac_dev_end (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_power_on_reset_n,
  sdac_link_if.dev                         lnk,
  output logic [`SDAC_WORD_BITS-1:0]       o_left,
  output logic [`SDAC_WORD_BITS-1:0]       o_right,
  output logic                             o_pair_valid,
  output sdac_pkg::sdac_ratio_t            o_ratio,
  output logic                             o_ratio_ok,
  output sdac_pkg::sdac_pwr_t              o_power_state,
  output logic [`SDAC_GAIN_BITS-1:0]       o_gain,
  output logic                             o_in_reset
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic sdac_near(input logic [`SDAC_MCNT_BITS-1:0] cnt,
                                     input int unsigned                nom);
    int unsigned c;
    c = int'(cnt);
    return (c + `SDAC_RATIO_TOL >= nom) && (c <= nom + `SDAC_RATIO_TOL);
  endfunction : sdac_near

  function automatic logic [`SDAC_WORD_BITS-1:0] sdac_scale(
      input logic [`SDAC_WORD_BITS-1:0] w,
      input logic [`SDAC_GAIN_BITS-1:0] g);
    logic signed [34:0] p;
    p = 35'($signed(w)) * 35'($signed({1'b0, g}));
    p = p / 35'(`SDAC_RAMP_LEN);
    return p[`SDAC_WORD_BITS-1:0];
  endfunction : sdac_scale

  function automatic logic [`SDAC_FCNT_BITS-1:0] sdac_per(input int unsigned hz);
    return `SDAC_FCNT_BITS'(`SDAC_CLK_HZ / hz);
  endfunction : sdac_per

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [`SDAC_SY_BITS-1:0] raw_w, s1_q, s2_q, s3_q;
  assign raw_w[`SDAC_SY_MCLK]  = lnk.master_clock;
  assign raw_w[`SDAC_SY_BCLK]  = lnk.bit_clock;
  assign raw_w[`SDAC_SY_LR]    = lnk.frame_sync;
  assign raw_w[`SDAC_SY_SD]    = lnk.serial_audio_in;
  assign raw_w[`SDAC_SY_MUTE]  = lnk.mute_n;
  assign raw_w[`SDAC_SY_FMT]   = lnk.format_select_out;
  assign raw_w[`SDAC_SY_FLOAT] = lnk.format_select_oe_n;
  assign raw_w[`SDAC_SY_POR]   = i_power_on_reset_n;

  genvar gi;
  generate
    for (gi = 0; gi < `SDAC_SY_BITS; gi++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= raw_w[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
        end
      end
    end
  endgenerate

  // supply comparator low holds the whole core, whether rising or falling
  wire core_rst_w = !i_rst_n || !s2_q[`SDAC_SY_POR];
  wire mclk_rise_w = s2_q[`SDAC_SY_MCLK] & ~s3_q[`SDAC_SY_MCLK];
  wire bclk_rise_w = s2_q[`SDAC_SY_BCLK] & ~s3_q[`SDAC_SY_BCLK];
  wire lr_w        = s2_q[`SDAC_SY_LR];
  wire frame_w     = lr_w & ~s3_q[`SDAC_SY_LR];
  wire sd_w        = s2_q[`SDAC_SY_SD];
  wire mute_n_w    = s2_q[`SDAC_SY_MUTE];
  wire sdac_pkg::sdac_fmt_t fmt_w = s2_q[`SDAC_SY_FLOAT] ? sdac_pkg::SDAC_FMT_RIGHT_JUSTIFIED :
                                    s2_q[`SDAC_SY_FMT]   ? sdac_pkg::SDAC_FMT_I2S :
                                    sdac_pkg::SDAC_FMT_LEFT_JUSTIFIED;

  // ****************************************************************
  // clock activity monitors
  // ****************************************************************
  localparam logic [`SDAC_IDLE_BITS-1:0] MCLK_LIM = `SDAC_IDLE_BITS'(`SDAC_MCLK_IDLE_CYC);
  localparam logic [`SDAC_IDLE_BITS-1:0] BCLK_LIM = `SDAC_IDLE_BITS'(`SDAC_BCLK_IDLE_CYC);
  logic [`SDAC_IDLE_BITS-1:0] idle_q [2];
  wire  [1:0]                 edge_w = {bclk_rise_w, mclk_rise_w};
  wire  [`SDAC_IDLE_BITS-1:0] lim_w  [2];
  wire  [1:0]                 act_w;
  assign lim_w[0] = MCLK_LIM;
  assign lim_w[1] = BCLK_LIM;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_act
      // counters start saturated so a fresh reset reads as no clock
      always_ff @(posedge i_clk) begin
        if (core_rst_w) begin
          idle_q[gi] <= lim_w[gi];
        end else if (edge_w[gi]) begin
          idle_q[gi] <= '0;
        end else if (idle_q[gi] != lim_w[gi]) begin
          idle_q[gi] <= idle_q[gi] + `SDAC_IDLE_BITS'(1);
        end
      end
      assign act_w[gi] = (idle_q[gi] != lim_w[gi]);
    end
  endgenerate
  wire mclk_act_w = act_w[0];
  wire bclk_act_w = act_w[1];

  // ****************************************************************
  // serial word receiver
  // ****************************************************************
  logic                       lr_last_q;
  logic [4:0]                 bitcnt_q;
  logic [`SDAC_WORD_BITS-1:0] shift_q;
  wire                        trans_w = (lr_w != lr_last_q);
  wire [4:0]                  idx_w   = trans_w ? 5'h00 : bitcnt_q;
  wire [`SDAC_WORD_BITS-1:0]  shin_w  = {shift_q[`SDAC_WORD_BITS-2:0], sd_w};
  wire                        is_rtj_w = (fmt_w == sdac_pkg::SDAC_FMT_RIGHT_JUSTIFIED);
  wire                        is_i2s_w = (fmt_w == sdac_pkg::SDAC_FMT_I2S);
  // right-justified closes the held word; idle edges after the transition fall out
  wire done_w = bclk_rise_w && (is_rtj_w ? trans_w :
                is_i2s_w ? (idx_w == 5'(`SDAC_WORD_BITS)) :
                (idx_w == 5'(`SDAC_WORD_BITS - 1)));
  wire [`SDAC_WORD_BITS-1:0]  word_w  = is_rtj_w ? shift_q : shin_w;
  wire                        chan_lr_w = is_rtj_w ? lr_last_q : lr_w;
  wire                        left_w  = is_i2s_w ? ~chan_lr_w : chan_lr_w;

  always_ff @(posedge i_clk) begin
    if (core_rst_w) begin
      lr_last_q <= 1'b0;
      bitcnt_q  <= 5'h00;
      shift_q   <= '0;
    end else if (bclk_rise_w) begin
      lr_last_q <= lr_w;
      shift_q   <= shin_w;
      if (idx_w != 5'h1f) begin
        bitcnt_q <= idx_w + 5'h01;
      end
    end
  end

  // ****************************************************************
  // ratio and rate measurement
  // ****************************************************************
  logic [`SDAC_MCNT_BITS-1:0] mcnt_q;
  logic [`SDAC_FCNT_BITS-1:0] fcnt_q;
  sdac_pkg::sdac_ratio_t      ratio_w;
  assign ratio_w = sdac_near(mcnt_q, `SDAC_NOM_R128)  ? sdac_pkg::SDAC_R128  :
                   sdac_near(mcnt_q, `SDAC_NOM_R192)  ? sdac_pkg::SDAC_R192  :
                   sdac_near(mcnt_q, `SDAC_NOM_R256)  ? sdac_pkg::SDAC_R256  :
                   sdac_near(mcnt_q, `SDAC_NOM_R384)  ? sdac_pkg::SDAC_R384  :
                   sdac_near(mcnt_q, `SDAC_NOM_R512)  ? sdac_pkg::SDAC_R512  :
                   sdac_near(mcnt_q, `SDAC_NOM_R768)  ? sdac_pkg::SDAC_R768  :
                   sdac_near(mcnt_q, `SDAC_NOM_R1152) ? sdac_pkg::SDAC_R1152 :
                   sdac_pkg::SDAC_RNONE;
  // rate limits checked on frame length in core cycles, with a little slack for jitter
  wire ge_88k2_w = (fcnt_q <= sdac_per(`SDAC_FS_88K2_HZ) + `SDAC_FCNT_BITS'(`SDAC_FS_SLACK));
  wire le_96k_w  = (fcnt_q + `SDAC_FCNT_BITS'(`SDAC_FS_SLACK) >= sdac_per(`SDAC_FS_96K_HZ));
  wire le_48k_w  = (fcnt_q + `SDAC_FCNT_BITS'(`SDAC_FS_SLACK) >= sdac_per(`SDAC_FS_48K_HZ));
  wire le_32k_w  = (fcnt_q + `SDAC_FCNT_BITS'(`SDAC_FS_SLACK) >= sdac_per(`SDAC_FS_32K_HZ));
  wire pair_ok_w = ((ratio_w == sdac_pkg::SDAC_R128) || (ratio_w == sdac_pkg::SDAC_R192)) ?
                   ge_88k2_w :
                   ((ratio_w == sdac_pkg::SDAC_R256) || (ratio_w == sdac_pkg::SDAC_R384)) ?
                   le_96k_w :
                   ((ratio_w == sdac_pkg::SDAC_R512) || (ratio_w == sdac_pkg::SDAC_R768)) ?
                   le_48k_w :
                   (ratio_w == sdac_pkg::SDAC_R1152) ? le_32k_w : 1'b0;

  always_ff @(posedge i_clk) begin
    if (core_rst_w || frame_w) begin
      mcnt_q <= '0;
      fcnt_q <= '0;
    end else begin
      if (mclk_rise_w && (mcnt_q != '1)) begin
        mcnt_q <= mcnt_q + `SDAC_MCNT_BITS'(1);
      end
      if (fcnt_q != '1) begin
        fcnt_q <= fcnt_q + `SDAC_FCNT_BITS'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (core_rst_w) begin
      o_ratio    <= sdac_pkg::SDAC_RNONE;
      o_ratio_ok <= 1'b0;
    end else if (frame_w) begin
      o_ratio    <= ratio_w;
      o_ratio_ok <= pair_ok_w;
    end
  end

  // ****************************************************************
  // soft mute ramp
  // ****************************************************************
  // without a bit clock there are no samples, so a fixed tick stands in
  logic [`SDAC_IDLE_BITS-1:0] tdiv_q;
  wire  tick_w   = (tdiv_q == `SDAC_IDLE_BITS'(`SDAC_RAMP_TICK_CYC - 1));
  wire  step_w   = bclk_act_w ? frame_w : tick_w;
  wire  play_w   = (o_power_state == sdac_pkg::SDAC_PWR_ENABLED) && mute_n_w &&
                   bclk_act_w;
  localparam logic [`SDAC_GAIN_BITS-1:0] GAIN_FULL = `SDAC_GAIN_BITS'(`SDAC_RAMP_LEN);

  always_ff @(posedge i_clk) begin
    if (core_rst_w || tick_w) begin
      tdiv_q <= '0;
    end else begin
      tdiv_q <= tdiv_q + `SDAC_IDLE_BITS'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (core_rst_w || (o_power_state == sdac_pkg::SDAC_PWR_OFF)) begin
      o_gain <= '0;
    end else if (play_w) begin
      o_gain <= GAIN_FULL;
    end else if (step_w && (o_gain != '0)) begin
      o_gain <= o_gain - `SDAC_GAIN_BITS'(1);
    end
  end

  // ****************************************************************
  // sample output
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (core_rst_w) begin
      o_left       <= '0;
      o_right      <= '0;
      o_pair_valid <= 1'b0;
    end else begin
      o_pair_valid <= done_w && !left_w;
      if (done_w && left_w) begin
        o_left <= sdac_scale(word_w, o_gain);
      end
      if (done_w && !left_w) begin
        o_right <= sdac_scale(word_w, o_gain);
      end
    end
  end

  // ****************************************************************
  // power state machine
  // ****************************************************************
  sdac_pkg::sdac_pwr_t pwr_d;
  always_comb begin
    pwr_d = o_power_state;
    case (o_power_state)
      sdac_pkg::SDAC_PWR_OFF: begin
        if (mclk_act_w && bclk_act_w) begin
          pwr_d = mute_n_w ? sdac_pkg::SDAC_PWR_ENABLED : sdac_pkg::SDAC_PWR_STANDBY;
        end
      end
      sdac_pkg::SDAC_PWR_STANDBY: begin
        if (!mclk_act_w) begin
          pwr_d = sdac_pkg::SDAC_PWR_OFF;
        end else if (mute_n_w && bclk_act_w) begin
          pwr_d = sdac_pkg::SDAC_PWR_ENABLED;
        end
      end
      sdac_pkg::SDAC_PWR_ENABLED: begin
        if (!mclk_act_w) begin
          pwr_d = sdac_pkg::SDAC_PWR_OFF;
        end else if (!play_w && (o_gain == '0)) begin
          pwr_d = sdac_pkg::SDAC_PWR_STANDBY;
        end
      end
      default: begin
        pwr_d = sdac_pkg::SDAC_PWR_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (core_rst_w) begin
      o_power_state <= sdac_pkg::SDAC_PWR_OFF;
      o_in_reset    <= 1'b1;
    end else begin
      o_power_state <= pwr_d;
      o_in_reset    <= 1'b0;
    end
  end
endmodule : sdac_dev_end
`default_nettype wire

/* verif/sdac_link_monitor.sv */
// checker for the link pins and the dac end's status outputs
// assumes one 200 MHz core clock with a synchronous active-low reset
`include "sdac_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sdac_link_monitor (
  input wire logic                       i_clk,
  input wire logic                       i_rst_n,
  input wire logic                       i_power_on_reset_n,
  input wire logic                       master_clock,
  input wire logic                       mute_n,
  input wire logic                       o_pair_valid,
  input wire logic [`SDAC_GAIN_BITS-1:0] o_gain,
  input wire sdac_pkg::sdac_pwr_t        o_power_state,
  input wire logic                       o_in_reset
);
  // **********
  // properties
  // **********
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // counts cycles since the master clock last moved, saturating
  logic [8:0] still_q;
  logic       mclk_q;
  wire  [8:0] still_d = (mclk_q != master_clock) ? 9'h000 : still_q + {8'h00, ~&still_q};
  always_ff @(posedge i_clk) begin
    mclk_q  <= master_clock;
    still_q <= i_rst_n ? still_d : 9'h000;
  end
  a_off_gain_zero: assert property (
    o_power_state == sdac_pkg::SDAC_PWR_OFF [*2] |-> o_gain == 10'h000)
    else $error("gain not zero while off");
  a_gain_in_range: assert property (o_gain <= 10'h320)
    else $error("gain above full scale");
  a_gain_ramp_step: assert property (
    o_gain < $past(o_gain) && o_power_state != sdac_pkg::SDAC_PWR_OFF
    |-> o_gain == $past(o_gain) - 10'h001) else $error("gain fell by more than one");
  a_reset_holds_off: assert property (o_in_reset |-> o_power_state == sdac_pkg::SDAC_PWR_OFF)
    else $error("state left off during reset");
  a_por_forces_reset: assert property (!i_power_on_reset_n [*4] |-> o_in_reset)
    else $error("core not held while supplies low");
  a_enable_needs_play: assert property (
    o_power_state == sdac_pkg::SDAC_PWR_ENABLED && $past(o_power_state) == sdac_pkg::SDAC_PWR_OFF
    |-> mute_n) else $error("enabled from off with mute low");
  a_standby_on_mute: assert property (
    o_power_state == sdac_pkg::SDAC_PWR_STANDBY && $past(o_power_state) == sdac_pkg::SDAC_PWR_OFF
    |-> !mute_n) else $error("standby from off with mute high");
  a_mclk_loss_off: assert property (still_q > 9'h0dc |-> o_power_state == sdac_pkg::SDAC_PWR_OFF)
    else $error("not off after master clock stop");
  a_pair_valid_pulse: assert property (o_pair_valid |=> !o_pair_valid)
    else $error("pair valid longer than one cycle");
  c_play: cover property (o_power_state == sdac_pkg::SDAC_PWR_ENABLED && o_pair_valid);
  c_standby: cover property (o_power_state == sdac_pkg::SDAC_PWR_STANDBY);
  c_ramp: cover property (o_gain < $past(o_gain));
endmodule : sdac_link_monitor
`default_nettype wire

/* verif/tb_stereo_dac_serial_input_ctrl.sv */
// self-checking bench: source end and dac end joined by the link interface
// assumes the design headers are on the include path
`include "sdac_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_stereo_dac_serial_input_ctrl;
  // ***********
  // bench state
  // ***********
  logic                       clk;
  logic                       rst_n;
  logic                       por_n;
  logic                       mute_n;
  logic                       mclk_run;
  logic                       bclk_run;
  logic                       pv;
  logic                       rok;
  logic                       in_rst;
  logic                       take;
  logic [`SDAC_WORD_BITS-1:0] left;
  logic [`SDAC_WORD_BITS-1:0] right;
  logic [`SDAC_WORD_BITS-1:0] ol;
  logic [`SDAC_WORD_BITS-1:0] orr;
  logic [`SDAC_GAIN_BITS-1:0] gain;
  sdac_pkg::sdac_fmt_t        fmt;
  sdac_pkg::sdac_ratio_t      ratio;
  sdac_pkg::sdac_pwr_t        pwr;
  int                         error_cnt;
  int                         num_checks;
  int                         takes;
  int                         t0;
  sdac_link_if lnk ();
  sdac_src_end i_sdac_src_end (.i_clk(clk), .i_rst_n(rst_n), .lnk(lnk), .i_left(left),
    .i_right(right), .i_mute_n(mute_n), .i_fmt(fmt), .i_mclk_run(mclk_run),
    .i_bclk_run(bclk_run), .o_take(take));
  sdac_dev_end i_sdac_dev_end (.i_clk(clk), .i_rst_n(rst_n), .i_power_on_reset_n(por_n),
    .lnk(lnk), .o_left(ol), .o_right(orr), .o_pair_valid(pv), .o_ratio(ratio),
    .o_ratio_ok(rok), .o_power_state(pwr), .o_gain(gain), .o_in_reset(in_rst));
  sdac_link_monitor i_sdac_link_monitor (.i_clk(clk), .i_rst_n(rst_n),
    .i_power_on_reset_n(por_n), .master_clock(lnk.master_clock), .mute_n(lnk.mute_n),
    .o_pair_valid(pv), .o_gain(gain), .o_power_state(pwr), .o_in_reset(in_rst));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // one latch strobe per frame from the source end
  always @(posedge clk) begin
    if (take === 1'b1) takes <= takes + 1;
  end
  // *****
  // tasks
  // *****
  task automatic wrap_up;
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : cmp
  task automatic hang;
    error_cnt++;
    $display("CHECK FAILED %0t wait ran out", $time);
    wrap_up();
  endtask : hang
  // waits for n pair strobes; a frame is 2048 core cycles
  task automatic wait_pairs(input int n);
    int k;
    for (k = 0; k < 20000 && n > 0; k++) begin
      tick(1);
      if (pv === 1'b1) n--;
    end
    if (n > 0) hang();
  endtask : wait_pairs
  task automatic wait_pwr(input sdac_pkg::sdac_pwr_t s, input int lim);
    int k;
    for (k = 0; k < lim && pwr !== s; k++) tick(1);
    if (pwr !== s) hang();
  endtask : wait_pwr
  // ********
  // sequence
  // ********
  initial begin
    error_cnt = 0;
    num_checks = 0;
    {rst_n, mclk_run, bclk_run} = 3'h0;
    {por_n, mute_n} = 2'h3;
    fmt = sdac_pkg::SDAC_FMT_LEFT_JUSTIFIED;
    left = 24'h9c3a51;
    right = 24'h63c5ae;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tick(4);
    cmp(pwr, sdac_pkg::SDAC_PWR_OFF);
    cmp(gain, 10'h000);
    @(posedge clk);
    {mclk_run, bclk_run} <= 2'h3;
    wait_pwr(sdac_pkg::SDAC_PWR_ENABLED, 3000);
    // format codes 0..2 are left-justified, i2s, right-justified
    for (int f = 0; f < 3; f++) begin
      @(posedge clk);
      fmt <= sdac_pkg::sdac_fmt_t'(f);
      left <= 24'h9c3a51 + 24'(f);
      right <= 24'h63c5ae - 24'(f);
      t0 = takes;
      wait_pairs(3);
      cmp(takes - t0 >= 2 && takes - t0 <= 4, 1'b1);
      cmp(ol, left);
      cmp(orr, right);
      cmp(ratio, sdac_pkg::SDAC_R128);
      cmp(rok, 1'b1);
    end
    @(posedge clk);
    mute_n <= 1'b0;
    tick(4400);
    cmp(gain < 10'h320 && gain > 10'h31c, 1'b1);
    @(posedge clk);
    mute_n <= 1'b1;
    tick(8);
    cmp(gain, 10'h320);
    @(posedge clk);
    bclk_run <= 1'b0;
    tick(13000);
    cmp(gain < 10'h320, 1'b1);
    @(posedge clk);
    {mclk_run, bclk_run} <= 2'h1;
    tick(250);
    cmp(pwr, sdac_pkg::SDAC_PWR_OFF);
    cmp(gain, 10'h000);
    @(posedge clk);
    {mute_n, mclk_run} <= 2'h1;
    wait_pwr(sdac_pkg::SDAC_PWR_STANDBY, 3000);
    @(posedge clk);
    bclk_run <= 1'b0;
    tick(6000);
    cmp(pwr, sdac_pkg::SDAC_PWR_STANDBY);
    @(posedge clk);
    {mute_n, bclk_run} <= 2'h3;
    wait_pwr(sdac_pkg::SDAC_PWR_ENABLED, 6000);
    @(posedge clk);
    por_n <= 1'b0;
    tick(5);
    cmp(in_rst, 1'b1);
    cmp(pwr, sdac_pkg::SDAC_PWR_OFF);
    @(posedge clk);
    por_n <= 1'b1;
    wait_pwr(sdac_pkg::SDAC_PWR_ENABLED, 3000);
    cmp(in_rst, 1'b0);
    wrap_up();
  end
endmodule : tb_stereo_dac_serial_input_ctrl
`default_nettype wire
